// file: lbsf_pkg.sv
// Package for the LED boost start-up and fault sequencer
package lbsf_pkg;
	localparam int unsigned CLK_HZ          = 250_000_000;
	localparam int unsigned SW_FREQ_HZ      = 600_000;
	localparam int unsigned OSC_DIV         = CLK_HZ / SW_FREQ_HZ;
	// Long-low time in tenths of a millisecond
	localparam int unsigned SHDN_LOW_US10   = 25;
	localparam int unsigned SHDN_CYC        =
		SHDN_LOW_US10 * (CLK_HZ / 10_000);
	localparam int unsigned STEP_US         = 213;
	localparam int unsigned STEP_PER        =
		(STEP_US * (SW_FREQ_HZ / 1000) + 999) / 1000;
	localparam int unsigned HALF_LIM_MS     = 5;
	localparam int unsigned HALF_LIM_PER    =
		HALF_LIM_MS * (SW_FREQ_HZ / 1000);
	localparam int unsigned SS_STEPS        = 32;
	localparam int unsigned OPEN_CNT        = 8;
	localparam logic [4:0]  REF_RST         = 5'h00;
	localparam logic [4:0]  REF_FINAL       = 5'h1f;

	typedef enum logic [1:0] {
		LBSF_OFF,
		LBSF_SOFT,
		LBSF_RUN,
		LBSF_FAULT
	} lbsf_state_t;

	typedef struct packed {
		logic       sw_en;
		logic       half_lim;
		logic       soft_done;
		logic [4:0] ref_step;
	} lbsf_drive_t;
endpackage

// file: lbsf_osc_div.sv
// Divider giving the switching-cycle enable pulse
`timescale 1ns/100ps
module lbsf_osc_div #(
	parameter int unsigned DIV = 416
) (
	input  wire logic I_SYS_CLK,  // System clock
	input  wire logic I_RST,      // Synchronous reset
	output logic      o_tick      // One pulse per switching cycle
);
	logic [15:0] cnt_ff;

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST || cnt_ff == 16'(DIV - 1)) begin
			cnt_ff <= 16'h0000;
		end else begin
			cnt_ff <= cnt_ff + 16'h0001;
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			o_tick <= 1'b0;
		end else begin
			o_tick <= (cnt_ff == 16'(DIV - 1));
		end
	end
endmodule

// file: lbsf_seq.sv
// Start-up, shutdown and open-LED fault sequencer of a boost LED driver
// Operation
// - The control pin enables the device when high and also carries dimming.
// - A control low held longer than 2.5 ms puts the device in shutdown.
// - In shutdown the power switch never switches.
// - After enable the reference rises in 32 steps of 213 us each.
// - For 5 ms after the ramp starts the switch limit is half.
// - Overvoltage with low feedback for 8 switching cycles trips shutdown.
// - After an open-LED trip only a toggle of the control pin re-enables.
// - Switching runs at 600 kHz, one sequencing count per period.
`timescale 1ns/100ps
module lbsf_seq #(
	parameter int unsigned SHDN_CYC = lbsf_pkg::SHDN_CYC,
	parameter int unsigned STEP_PER = lbsf_pkg::STEP_PER,
	parameter int unsigned HALF_PER = lbsf_pkg::HALF_LIM_PER
) (
	input  wire logic       I_SYS_CLK,    // 250 MHz clock
	input  wire logic       I_RST,        // Synchronous reset, active high
	input  wire logic       I_CTRL,       // Control pin, async
	input  wire logic       I_OVP_CMP,    // Inductor_node overvoltage, async
	input  wire logic       I_FDBK_LOW_CMP, // Feedback_sense below half
	output logic            O_SW_EN,      // Power switch may switch
	output logic            O_HALF_LIM,   // Half current limit selected
	output logic [4:0]      O_REF_STEP,   // Reference step 0..31
	output logic            O_SOFT_DONE,  // Soft start finished
	output logic            O_FAULT,      // Open-LED latch
	output logic            O_SW_TICK     // Switching period pulse, only while the switch is enabled
);
	logic                 ctrl_m_ff, ctrl_ff, ctrl_d_ff;
	logic                 ovp_m_ff, ovp_ff, fbl_m_ff, fbl_ff;
	logic                 tick;
	logic [20:0]          low_cnt_ff;
	logic                 shdn_ff;
	lbsf_pkg::lbsf_state_t state_ff, nxt_state;
	logic [7:0]           step_cnt_ff;
	logic [4:0]           ref_ff;
	logic [11:0]          half_cnt_ff;
	logic [3:0]           open_cnt_ff;
	logic                 rise;
	logic                 trip;
	lbsf_pkg::lbsf_drive_t drv;

	// Two-stage synchronisers
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			ctrl_m_ff <= 1'b0;
			ctrl_ff   <= 1'b0;
			ovp_m_ff  <= 1'b0;
			ovp_ff    <= 1'b0;
			fbl_m_ff  <= 1'b0;
			fbl_ff    <= 1'b0;
		end else begin
			ctrl_m_ff <= I_CTRL;
			ctrl_ff   <= ctrl_m_ff;
			ovp_m_ff  <= I_OVP_CMP;
			ovp_ff    <= ovp_m_ff;
			fbl_m_ff  <= I_FDBK_LOW_CMP;
			fbl_ff    <= fbl_m_ff;
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			ctrl_d_ff <= 1'b0;
		end else begin
			ctrl_d_ff <= ctrl_ff;
		end
	end

	assign rise = ctrl_ff && !ctrl_d_ff;

	lbsf_osc_div #(
		.DIV (lbsf_pkg::OSC_DIV)
	) u_div (
		.I_SYS_CLK (I_SYS_CLK),
		.I_RST     (I_RST),
		.o_tick    (tick)
	);

	// Long-low detector
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST || ctrl_ff) begin
			low_cnt_ff <= 21'h000000;
			shdn_ff    <= I_RST;
		end else if (low_cnt_ff == 21'(SHDN_CYC)) begin
			shdn_ff    <= 1'b1;
		end else begin
			low_cnt_ff <= low_cnt_ff + 21'h000001;
		end
	end

	// Open-LED persistence counter
	assign trip = (open_cnt_ff == 4'(lbsf_pkg::OPEN_CNT - 1)) && tick
		&& ovp_ff && fbl_ff;
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST || !(ovp_ff && fbl_ff) || !O_SW_EN) begin
			open_cnt_ff <= 4'h0;
		end else if (tick && !trip) begin
			open_cnt_ff <= open_cnt_ff + 4'h1;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			lbsf_pkg::LBSF_OFF:
				if (ctrl_ff && !shdn_ff) nxt_state = lbsf_pkg::LBSF_SOFT;
			lbsf_pkg::LBSF_SOFT, lbsf_pkg::LBSF_RUN: begin
				// A trip wins over a long low so the fault is latched
				if (trip) begin
					nxt_state = lbsf_pkg::LBSF_FAULT;
				end else if (shdn_ff) begin
					nxt_state = lbsf_pkg::LBSF_OFF;
				end else if (state_ff == lbsf_pkg::LBSF_SOFT && tick
					&& ref_ff == lbsf_pkg::REF_FINAL
					&& step_cnt_ff == 8'(STEP_PER - 1)) begin
					nxt_state = lbsf_pkg::LBSF_RUN;
				end
			end
			lbsf_pkg::LBSF_FAULT:
				if (rise) nxt_state = lbsf_pkg::LBSF_SOFT;
		endcase
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			state_ff <= lbsf_pkg::LBSF_OFF;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Reference ramp, 32 steps
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST || state_ff != lbsf_pkg::LBSF_SOFT
			|| nxt_state != lbsf_pkg::LBSF_SOFT) begin
			step_cnt_ff <= 8'h00;
			ref_ff      <= (nxt_state == lbsf_pkg::LBSF_RUN) ?
				lbsf_pkg::REF_FINAL : lbsf_pkg::REF_RST;
		end else if (tick) begin
			if (step_cnt_ff == 8'(STEP_PER - 1)) begin
				step_cnt_ff <= 8'h00;
				ref_ff      <= ref_ff + 5'h01;
			end else begin
				step_cnt_ff <= step_cnt_ff + 8'h01;
			end
		end
	end

	// Half current limit window
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST || state_ff == lbsf_pkg::LBSF_OFF
			|| state_ff == lbsf_pkg::LBSF_FAULT) begin
			half_cnt_ff <= 12'h000;
		end else if (tick && half_cnt_ff != 12'(HALF_PER)) begin
			half_cnt_ff <= half_cnt_ff + 12'h001;
		end
	end

	always_comb begin
		drv.sw_en     = (state_ff == lbsf_pkg::LBSF_SOFT
			|| state_ff == lbsf_pkg::LBSF_RUN) && !trip;
		drv.half_lim  = drv.sw_en && half_cnt_ff != 12'(HALF_PER);
		drv.soft_done = state_ff == lbsf_pkg::LBSF_RUN;
		drv.ref_step  = ref_ff;
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			O_SW_EN     <= 1'b0;
			O_HALF_LIM  <= 1'b0;
			O_SOFT_DONE <= 1'b0;
			O_REF_STEP  <= lbsf_pkg::REF_RST;
			O_FAULT     <= 1'b0;
			O_SW_TICK   <= 1'b0;
		end else begin
			O_SW_EN     <= drv.sw_en;
			O_HALF_LIM  <= drv.half_lim;
			O_SOFT_DONE <= drv.soft_done;
			O_REF_STEP  <= drv.ref_step;
			O_FAULT     <= state_ff == lbsf_pkg::LBSF_FAULT;
			O_SW_TICK   <= tick && drv.sw_en;
		end
	end

	sequence s_qualify_run;
		ovp_ff && fbl_ff && tick ##1 (ovp_ff && fbl_ff)[*1];
	endsequence

	AST_OFF_NO_SW: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(state_ff == lbsf_pkg::LBSF_OFF) |=> !O_SW_EN)
		else $error("switch enabled in shutdown");
	AST_SHDN_TIME: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		$rose(shdn_ff) |-> low_cnt_ff == 21'(SHDN_CYC))
		else $error("shutdown before low time");
	AST_FAULT_HOLD: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(state_ff == lbsf_pkg::LBSF_FAULT && !rise) |=>
		state_ff == lbsf_pkg::LBSF_FAULT)
		else $error("fault released without toggle");
	AST_TRIP_CNT: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		trip |-> open_cnt_ff == 4'h7 ##1 state_ff == lbsf_pkg::LBSF_FAULT)
		else $error("trip at wrong count");
	AST_CNT_CLR: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		!(ovp_ff && fbl_ff) |=> open_cnt_ff == 4'h0)
		else $error("open count not cleared");
	AST_STEP_INC: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(state_ff == lbsf_pkg::LBSF_SOFT && $changed(ref_ff)) |->
		ref_ff == $past(ref_ff) + 5'h01 || ref_ff == lbsf_pkg::REF_RST)
		else $error("reference step not by one");
	AST_HALF_EARLY: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		$rose(drv.sw_en) && half_cnt_ff == 12'h000 |=> O_HALF_LIM)
		else $error("half limit missing at start");
	AST_SEQ_COUNT: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		s_qualify_run |-> open_cnt_ff != 4'h0 || !$past(O_SW_EN) || trip
		|| $past(trip))
		else $error("qualifying cycle not counted");
endmodule

// file: lbsf_host.sv
// Host model driving the control pin and the comparators
`timescale 1ns/100ps
module lbsf_host (
	input  wire logic i_clk,   // System clock
	output logic      o_ctrl,  // Control pin
	output logic      o_ovp,   // Overvoltage comparator
	output logic      o_fbl    // Feedback low comparator
);
	initial begin
		o_ctrl = 1'h0;
		o_ovp = 1'h0;
		o_fbl = 1'h0;
	end
	task automatic drive_ctrl(input logic lvl, input int cyc);
		@(negedge i_clk);
		o_ctrl = lvl;
		repeat (cyc) @(negedge i_clk);
	endtask
	// Low pulse then high: the toggle that clears a fault
	task automatic toggle(input int low_cyc);
		drive_ctrl(1'h0, low_cyc);
		drive_ctrl(1'h1, 1);
	endtask
	task automatic set_cmp(input logic ovp, input logic fbl);
		o_ovp = ovp;
		o_fbl = fbl;
	endtask
endmodule

// file: tb_top.sv
// Self-checking testbench for the start-up and fault sequencer
`timescale 1ns/100ps
module tb_top;
	localparam int SHDN = 50;
	localparam int STEP = 2;
	localparam int HALF = 40;
	logic       clk;
	logic       rst;
	logic       ctrl, ovp, fbl, sw_en, half_lim, soft_done, fault, tick;
	logic [4:0] ref_step;
	int         mismatches;
	int         cmp_count;
	int         n;
	int         k;

	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end

	lbsf_host HOST (.i_clk(clk), .o_ctrl(ctrl), .o_ovp(ovp), .o_fbl(fbl));
	lbsf_seq #(.SHDN_CYC(SHDN), .STEP_PER(STEP), .HALF_PER(HALF)) DUT (
		.I_SYS_CLK(clk), .I_RST(rst), .I_CTRL(ctrl), .I_OVP_CMP(ovp),
		.I_FDBK_LOW_CMP(fbl), .O_SW_EN(sw_en), .O_HALF_LIM(half_lim),
		.O_REF_STEP(ref_step), .O_SOFT_DONE(soft_done), .O_FAULT(fault),
		.O_SW_TICK(tick)
	);

	task automatic chk_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t flag %b exp %b", $time, got, exp);
		end
	endtask
	task automatic chk_ref(input logic [4:0] got, input logic [4:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t step %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_cnt(input int got, input int exp);
		cmp_count++;
		if (got != exp) begin
			mismatches++;
			$display("[FAIL] %0t count %0d exp %0d", $time, got, exp);
		end
	endtask
	// Returns cycles waited in n; a missing tick counts as a mismatch
	task automatic wait_tick();
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (tick !== 1'h1 && n < 1000);
		if (n >= 1000) chk_bit(1'h0, 1'h1);
	endtask
	task automatic give_verdict();
		if (mismatches == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic t_start();
		HOST.drive_ctrl(1'h1, 8);
		chk_bit(sw_en, 1'h1);
		chk_bit(half_lim, 1'h1);
		chk_ref(ref_step, 5'h00);
		chk_bit(soft_done, 1'h0);
	endtask
	task automatic t_step();
		wait_tick();
		wait_tick();
		chk_cnt(n, lbsf_pkg::OSC_DIV);
		chk_ref(ref_step, 5'h00);
		wait_tick();
		chk_ref(ref_step, 5'h01);
		repeat (HALF - 3) wait_tick();
		chk_bit(half_lim, 1'h1);
		wait_tick();
		chk_bit(half_lim, 1'h0);
		repeat (lbsf_pkg::SS_STEPS * STEP - HALF - 1) wait_tick();
		chk_ref(ref_step, lbsf_pkg::REF_FINAL);
		chk_bit(soft_done, 1'h0);
		@(negedge clk);
		chk_bit(soft_done, 1'h1);
		chk_ref(ref_step, lbsf_pkg::REF_FINAL);
	endtask
	task automatic t_low();
		HOST.drive_ctrl(1'h0, SHDN - 15);
		HOST.drive_ctrl(1'h1, 6);
		chk_bit(sw_en, 1'h1);
		HOST.drive_ctrl(1'h0, SHDN + 10);
		chk_bit(sw_en, 1'h0);
		k = 0;
		repeat (1000) begin
			@(negedge clk);
			if (tick === 1'h1) k++;
		end
		chk_cnt(k, 0);
		HOST.drive_ctrl(1'h1, 8);
		chk_bit(sw_en, 1'h1);
		chk_ref(ref_step, 5'h00);
	endtask
	task automatic t_fault();
		wait_tick();
		HOST.set_cmp(1'h1, 1'h1);
		repeat (7) wait_tick();
		chk_bit(fault, 1'h0);
		HOST.set_cmp(1'h1, 1'h0);
		wait_tick();
		HOST.set_cmp(1'h1, 1'h1);
		repeat (7) wait_tick();
		chk_bit(fault, 1'h0);
		// The tripping period shows no tick, so wait one period by count
		repeat (lbsf_pkg::OSC_DIV + 4) @(negedge clk);
		chk_bit(fault, 1'h1);
		chk_bit(sw_en, 1'h0);
	endtask
	task automatic t_latch();
		HOST.set_cmp(1'h0, 1'h0);
		HOST.drive_ctrl(1'h1, SHDN * 3);
		chk_bit(fault, 1'h1);
		chk_bit(sw_en, 1'h0);
		HOST.toggle(10);
		repeat (8) @(negedge clk);
		chk_bit(fault, 1'h0);
		chk_bit(sw_en, 1'h1);
	endtask

	initial begin
		rst = 1'h1;
		mismatches = 0;
		cmp_count = 0;
		repeat (6) @(negedge clk);
		rst = 1'h0;
		@(negedge clk);
		chk_bit(sw_en, 1'h0);
		t_start();
		t_step();
		t_low();
		t_fault();
		t_latch();
		give_verdict();
	end

	initial begin
		#360000;
		mismatches++;
		give_verdict();
	end
endmodule
